// File: src/pfr_pkg.sv
/*
  package of the failure-reaction block: register offsets, build word
  fields, reaction codes, response codes and interrupt bits.
  assumes a 32-bit AXI4-Lite programming port with word-aligned offsets.
*/
package pfr_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFF_BUILD = 12'h000;
  localparam logic [11:0] OFF_REACT = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_IEN = 12'h00C;
  localparam logic [11:0] OFF_ICLR = 12'h010;
  localparam int ADDR_W = 12;

  // ************************************************************
  // build information word
  // ************************************************************
  localparam int FILT_LSB = 24;
  localparam int FILT_MSB = 25;
  localparam int AWID_LSB = 8;
  localparam int AWID_MSB = 13;
  localparam int REGN_LSB = 0;
  localparam int REGN_MSB = 4;
  localparam logic [1:0] FILT_ONE = 2'h0;
  localparam logic [1:0] FILT_TWO = 2'h1;
  localparam logic [1:0] FILT_FOUR = 2'h3;
  localparam logic [5:0] AWID_32 = 6'h1F;
  localparam logic [5:0] AWID_36 = 6'h23;
  localparam logic [5:0] AWID_40 = 6'h27;
  localparam logic [5:0] AWID_48 = 6'h2F;
  localparam logic [5:0] AWID_64 = 6'h3F;
  localparam logic [4:0] REGN_NINE = 5'h08;
  localparam logic [1:0] FILT_CODE = FILT_FOUR;
  localparam logic [5:0] AWID_CODE = AWID_32;

  // ************************************************************
  // reaction field, responses, interrupt bits
  // ************************************************************
  localparam int REACT_W = 2;
  localparam logic [1:0] REACT_RST = 2'h0;
  localparam int REACT_IRQ_BIT = 1;
  localparam int REACT_ERR_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] OVL_RESP = RESP_DECERR;
  localparam int REGION_W = 4;
  localparam int EV_W = 2;
  localparam int EV_PERM = 0;
  localparam int EV_OVL = 1;
  localparam logic [1:0] IEN_RST = 2'h3;

endpackage

// File: src/pfr_react_decode.sv
/*
  combinational decode of one permission check result into the bus
  response code and the interrupt events it raises.
  assumes the reaction field comes from the register block.
*/
`timescale 1ns/1ps
`default_nettype none

module pfr_react_decode (
  // reaction setting
  input wire logic [1:0] reaction,
  // check result
  input wire logic chk_valid,
  input wire logic perm_fail,
  input wire logic overlap,
  input wire logic [3:0] overlap_region,
  // decoded
  output logic [1:0] resp,
  output logic [1:0] events
);

  // ************************************************************
  // response and event decode
  // ************************************************************
  always_comb begin
    resp = pfr_pkg::RESP_OKAY;
    events = '0;
    if (chk_valid && overlap) begin
      resp = pfr_pkg::OVL_RESP;
      events[pfr_pkg::EV_OVL] = (overlap_region != 4'h0);
    end else if (chk_valid && perm_fail) begin
      resp = reaction[pfr_pkg::REACT_ERR_BIT] ? pfr_pkg::RESP_DECERR
                                              : pfr_pkg::RESP_OKAY;
      events[pfr_pkg::EV_PERM] = 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: src/pfr_top.sv
/*
  build information and failure-reaction registers behind an AXI4-Lite
  slave, with response selection for failing transactions and a level
  security failure interrupt.
  assumes one clock, AXI4-Lite masters that keep valid and payload
  steady until taken, and check results synchronous to clk.
*/
// Contract
// - filter unit count in bits 25:24
// - address width code in bits 13:8
// - region count always reads 0b01000
// - reaction field picks irq and response
// - code 00: irq low, OKAY
// - code 01: irq low, DECERR
// - code 10: irq high, OKAY
// - code 11: irq high, DECERR
// - overlap region>=1: irq follows bit 1
// - overlap response not taken from field
`timescale 1ns/1ps
`default_nettype none

module pfr_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // permission check result
  input wire logic chk_valid,
  input wire logic chk_write,
  input wire logic chk_perm_fail,
  input wire logic chk_overlap,
  input wire logic [3:0] chk_overlap_region,
  // failing transaction response
  output logic resp_valid,
  output logic [1:0] write_resp_secure_side,
  output logic [1:0] read_resp_secure_side,
  // interrupt
  output logic security_fail_irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic [1:0] react_r;
  logic [1:0] stat_r;
  logic [1:0] ien_r;
  logic [1:0] clr_fire;
  logic [1:0] stat_nxt;
  logic aw_got_r;
  logic w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_do;
  logic rd_build_r;
  logic rd_react_r;
  logic [1:0] dec_resp;
  logic [1:0] dec_ev;

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    is_reg = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = is_reg(a, pfr_pkg::OFF_BUILD) || is_reg(a, pfr_pkg::OFF_REACT) ||
             is_reg(a, pfr_pkg::OFF_STAT) || is_reg(a, pfr_pkg::OFF_IEN) ||
             is_reg(a, pfr_pkg::OFF_ICLR);
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input logic [1:0] react,
                                            input logic [1:0] stat,
                                            input logic [1:0] ien);
    read_word = 32'h0000_0000;
    if (is_reg(a, pfr_pkg::OFF_BUILD)) begin
      read_word[pfr_pkg::FILT_MSB:pfr_pkg::FILT_LSB] = pfr_pkg::FILT_CODE;
      read_word[pfr_pkg::AWID_MSB:pfr_pkg::AWID_LSB] = pfr_pkg::AWID_CODE;
      read_word[pfr_pkg::REGN_MSB:pfr_pkg::REGN_LSB] = pfr_pkg::REGN_NINE;
    end else if (is_reg(a, pfr_pkg::OFF_REACT)) begin
      read_word[1:0] = react;
    end else if (is_reg(a, pfr_pkg::OFF_STAT)) begin
      read_word[1:0] = stat;
    end else if (is_reg(a, pfr_pkg::OFF_IEN)) begin
      read_word[1:0] = ien;
    end
  endfunction

  // ************************************************************
  // write channel
  // ************************************************************
  assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pfr_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_r) ? pfr_pkg::RESP_OKAY : pfr_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      react_r <= pfr_pkg::REACT_RST;
      ien_r <= pfr_pkg::IEN_RST;
    end else if (ce && wr_do && wstrb_r[0]) begin
      if (is_reg(awaddr_r, pfr_pkg::OFF_REACT)) begin
        react_r <= wdata_r[1:0];
      end
      if (is_reg(awaddr_r, pfr_pkg::OFF_IEN)) begin
        ien_r <= wdata_r[1:0];
      end
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pfr_pkg::RESP_OKAY;
      rd_build_r <= 1'b0;
      rd_react_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word(s_axi_araddr, react_r, stat_r, ien_r);
        s_axi_rresp <= mapped(s_axi_araddr) ? pfr_pkg::RESP_OKAY : pfr_pkg::RESP_SLVERR;
        rd_build_r <= is_reg(s_axi_araddr, pfr_pkg::OFF_BUILD);
        rd_react_r <= is_reg(s_axi_araddr, pfr_pkg::OFF_REACT);
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // check result decode and response
  // ************************************************************
  pfr_react_decode u_dec (
    .reaction(react_r),
    .chk_valid(chk_valid),
    .perm_fail(chk_perm_fail),
    .overlap(chk_overlap),
    .overlap_region(chk_overlap_region),
    .resp(dec_resp),
    .events(dec_ev)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      write_resp_secure_side <= pfr_pkg::RESP_OKAY;
      read_resp_secure_side <= pfr_pkg::RESP_OKAY;
    end else if (ce) begin
      resp_valid <= chk_valid;
      if (chk_valid && chk_write) begin
        write_resp_secure_side <= dec_resp;
      end
      if (chk_valid && !chk_write) begin
        read_resp_secure_side <= dec_resp;
      end
    end
  end

  // ************************************************************
  // interrupt status, enable, clear
  // ************************************************************
  assign clr_fire = (wr_do && wstrb_r[0] && is_reg(awaddr_r, pfr_pkg::OFF_ICLR))
                    ? wdata_r[1:0] : 2'h0;
  assign stat_nxt = (stat_r & ~clr_fire) | dec_ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      security_fail_irq <= 1'b0;
    end else if (ce) begin
      security_fail_irq <= react_r[pfr_pkg::REACT_IRQ_BIT] && |(stat_r & ien_r);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  resp_okay_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_write && chk_perm_fail && !chk_overlap && !react_r[0]
    |=> resp_valid && write_resp_secure_side == 2'h0)
    else $error("failing write with okay code not answered okay");

  resp_decerr_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && !chk_write && chk_perm_fail && !chk_overlap && react_r[0]
    |=> resp_valid && read_resp_secure_side == 2'h3)
    else $error("failing read with error code not answered decerr");

  ovl_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_overlap && chk_write
    |=> write_resp_secure_side == 2'h3)
    else $error("overlap response followed the reaction field");

  irq_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !react_r[1] |=> !security_fail_irq)
    else $error("interrupt high with reaction bit one low");

  irq_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_perm_fail && !chk_overlap && ien_r[0] && react_r[1]
    ##1 (ce && react_r[1] && ien_r[0] && clr_fire == 2'h0) |=> security_fail_irq)
    else $error("permission failure did not raise the interrupt");

  ovl_region0_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_overlap && chk_overlap_region == 4'h0 && !stat_r[1]
    |=> !stat_r[1])
    else $error("overlap of region zero raised the overlap event");

  build_filt_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && rd_build_r |-> s_axi_rdata[25:24] == 2'h3)
    else $error("filter unit count field wrong");

  build_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && rd_build_r |-> s_axi_rdata[13:8] == 6'h1F)
    else $error("address width field wrong");

  build_region_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && rd_build_r
    |-> s_axi_rdata[4:0] == 5'h08 && s_axi_rdata[31:26] == 6'h00 && s_axi_rdata[23:14] == 10'h000)
    else $error("region count or reserved build bits wrong");

  react_resv_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && s_axi_arvalid && s_axi_arready && is_reg(s_axi_araddr, pfr_pkg::OFF_REACT)
    |=> rd_react_r && s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[1:0] == $past(react_r))
    else $error("reaction word read back wrong");

  react_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_do && wstrb_r[0] && is_reg(awaddr_r, pfr_pkg::OFF_REACT)
    |=> {30'h0, react_r} == ($past(wdata_r) & 32'h0000_0003))
    else $error("reaction field did not take the written low bits");

  perm_ok_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && !chk_write && chk_perm_fail && !chk_overlap && !react_r[0]
    |=> resp_valid && read_resp_secure_side == 2'h0)
    else $error("failing read with okay code not answered okay");

  perm_err_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_write && chk_perm_fail && !chk_overlap && react_r[0]
    |=> resp_valid && write_resp_secure_side == 2'h3)
    else $error("failing write with error code not answered decerr");

  ovl_resp_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_overlap && !chk_write
    |=> read_resp_secure_side == 2'h3)
    else $error("overlap read response followed the reaction field");

  ovl_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && chk_valid && chk_overlap && chk_overlap_region != 4'h0 && ien_r[1] && react_r[1]
    ##1 (ce && react_r[1] && ien_r[1] && clr_fire == 2'h0) |=> security_fail_irq)
    else $error("overlap of an upper region did not raise the interrupt");

  resp_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> resp_valid == $past(chk_valid))
    else $error("response strobe did not follow the check port");

  stat_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && stat_r[0] && !clr_fire[0] |=> stat_r[0])
    else $error("permission status bit lost without a clear");

  ce_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(stat_r) && $stable(react_r) &&
            $stable(security_fail_irq) && $stable(resp_valid))
    else $error("state moved while the clock enable was low");

  perm_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    chk_valid && chk_perm_fail && react_r == 2'h3 ##2 security_fail_irq);
  ovl_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    chk_valid && chk_overlap && chk_overlap_region != 4'h0 ##1 stat_r[1]);
  wr_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready);
  rd_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready && rd_build_r);
  frz_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    !ce && chk_valid);

endmodule
`default_nettype wire

// File: tb/pfr_chk_src.sv
/*
  partner model: the bus masters whose transactions are checked, seen as
  one check result per cycle on the check port.
  assumes the bench calls send right after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pfr_chk_src (
  // clock
  input wire logic clk,
  // check result
  output logic chk_valid,
  output logic chk_write,
  output logic chk_perm_fail,
  output logic chk_overlap,
  output logic [3:0] chk_overlap_region
);
  // ************************************************************
  // one result per call, fields scrambled while idle
  // ************************************************************
  initial begin
    chk_valid = 1'b0;
    chk_write = 1'b0;
    chk_perm_fail = 1'b0;
    chk_overlap = 1'b0;
    chk_overlap_region = 4'h0;
  end

  task automatic send(input logic w, input logic pf, input logic ov, input logic [3:0] rg);
    chk_valid <= 1'b1;
    chk_write <= w;
    chk_perm_fail <= pf;
    chk_overlap <= ov;
    chk_overlap_region <= rg;
    @(posedge clk);
    chk_valid <= 1'b0;
    chk_write <= ~w;
    chk_perm_fail <= ~pf;
    chk_overlap <= ~ov;
    chk_overlap_region <= ~rg;
  endtask
endmodule

`default_nettype wire

// File: tb/pfr_top_bench.sv
/*
  self-checking bench of the failure-reaction block.
  assumes pfr_top and the partner model pfr_chk_src are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module pfr_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, chk_overlap_region;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, write_resp_secure_side, read_resp_secure_side;
  logic chk_valid, chk_write, chk_perm_fail, chk_overlap, resp_valid, security_fail_irq;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] d;
  logic [1:0] r;

  always #4 clk = ~clk;

  pfr_top DUT (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chk_valid, .chk_write,
    .chk_perm_fail, .chk_overlap, .chk_overlap_region, .resp_valid,
    .write_resp_secure_side, .read_resp_secure_side, .security_fail_irq);

  pfr_chk_src SRC (.clk, .chk_valid, .chk_write, .chk_perm_fail, .chk_overlap,
    .chk_overlap_region);

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic aw_d, w_d;
    n = 0;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d) && n < 100) begin
      @(posedge clk);
      n++;
      if (!aw_d && s_axi_awready === 1'b1) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready === 1'b1) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask

  // one check result, then response, irq and status
  task automatic fire(input logic w, input logic pf, input logic ov, input logic [3:0] rg,
                      input logic [1:0] er, input logic ei);
    logic [1:0] st;
    st = {ov && rg != 4'h0, pf && !ov};
    SRC.send(w, pf, ov, rg);
    @(posedge clk);
    chk({31'h0, resp_valid}, 32'h1);
    chk({30'h0, w ? write_resp_secure_side : read_resp_secure_side}, {30'h0, er});
    @(posedge clk);
    chk({31'h0, security_fail_irq}, {31'h0, ei});
    axr(pfr_pkg::OFF_STAT, d, r);
    chk(d, {30'h0, st});
  endtask

  task automatic clr();
    axw(pfr_pkg::OFF_ICLR, 32'h3, r);
    @(posedge clk);
    chk({31'h0, security_fail_irq}, 32'h0);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_build();
    axr(pfr_pkg::OFF_BUILD, d, r);
    chk(d, 32'h0300_1F08);
    chk({30'h0, r}, 32'h0);
    axw(pfr_pkg::OFF_BUILD, 32'h0, r);
    chk({30'h0, r}, 32'h0);
    axr(pfr_pkg::OFF_BUILD, d, r);
    chk(d, 32'h0300_1F08);
    axr(pfr_pkg::OFF_REACT, d, r);
    chk(d, 32'h0);
    axw(pfr_pkg::OFF_REACT, 32'hFFFF_FFFE, r);
    axr(pfr_pkg::OFF_REACT, d, r);
    chk(d, 32'h2);
    axr(12'h100, d, r);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    axw(12'h100, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, 32'h2);
  endtask

  task automatic t_codes();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      axw(pfr_pkg::OFF_REACT, {30'h0, c}, r);
      for (int w = 0; w < 2; w++) begin
        fire(w[0], 1'b1, 1'b0, 4'h0, c[0] ? 2'h3 : 2'h0, c[1]);
        clr();
        fire(w[0], 1'b0, 1'b1, 4'h1 + w[3:0] * 4'h7, 2'h3, c[1]);
        clr();
        fire(w[0], 1'b1, 1'b1, 4'h0, 2'h3, 1'b0);
        fire(w[0], 1'b0, 1'b0, 4'h0, 2'h0, 1'b0);
      end
    end
  endtask

  task automatic t_mask();
    axw(pfr_pkg::OFF_IEN, 32'h0, r);
    axw(pfr_pkg::OFF_REACT, 32'h2, r);
    fire(1'b1, 1'b1, 1'b0, 4'h0, 2'h0, 1'b0);
    axw(pfr_pkg::OFF_IEN, 32'h1, r);
    repeat (2) @(posedge clk);
    chk({31'h0, security_fail_irq}, 32'h1);
    clr();
  endtask

  // clock enable low freezes everything, then a reset in mid-run
  task automatic t_freeze();
    axw(pfr_pkg::OFF_REACT, 32'h3, r);
    ce <= 1'b0;
    SRC.send(1'b1, 1'b1, 1'b0, 4'h0);
    ce <= 1'b1;
    @(posedge clk);
    chk({31'h0, resp_valid}, 32'h0);
    axr(pfr_pkg::OFF_STAT, d, r);
    chk(d, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(pfr_pkg::OFF_REACT, d, r);
    chk(d, 32'h0);
    axr(pfr_pkg::OFF_IEN, d, r);
    chk(d, 32'h3);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_build();
    t_codes();
    t_mask();
    t_freeze();
    results();
  end

  initial begin
    #200000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule

`default_nettype wire
